// ===== hw/fcd_device.sv
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "fcd_defs.svh"
module fcd_device #(
   parameter int CHANNELS = 4
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   fcd_link_if.device link
);
   typedef enum logic [2:0] {
      FCD_IDLE, FCD_GRANT_WAIT, FCD_S0, FCD_S1, FCD_S2, FCD_S3, FCD_SW, FCD_S4
   } fcd_state_e;
   // ==========================================
   // registers
   logic [15:0] addr_reg [CHANNELS];
   logic [15:0] cnt_reg [CHANNELS];
   logic [7:0] mode_reg;
   logic [CHANNELS-1:0] done_reg;
   logic reload_reg;
   logic toggle_reg;
   logic [7:0] rdata_reg;
   fcd_state_e state_reg;
   logic [1:0] sel_reg;
   logic hrq_reg, aen_reg, memrd_reg, memwr_reg, iord_reg, iowr_reg, tc_reg, mark_reg;
   logic oe_reg;
   logic [7:0] alow_reg, dout_reg;
   logic [CHANNELS-1:0] channel_grant_out_reg;
   // ==========================================
   // decode
   wire [2:0] reg_ch = link.reg_addr[3:1];
   wire is_chan = (link.reg_addr < `FCD_OFS_MODE_SET);
   wire is_cnt = link.reg_addr[0];
   wire [CHANNELS-1:0] live_req = link.dma_request & mode_reg[CHANNELS-1:0];
   wire any_req = |live_req;
   wire [1:0] pick = live_req[0] ? 2'h0 : live_req[1] ? 2'h1 : live_req[2] ? 2'h2 : 2'h3;
   wire [15:0] sel_cnt = cnt_reg[sel_reg];
   wire [15:0] sel_addr = addr_reg[sel_reg];
   fcd_pkg::fcd_xfer_e xfer;
   assign xfer = fcd_pkg::fcd_xfer_e'({sel_cnt[`FCD_CNT_RD_BIT], sel_cnt[`FCD_CNT_WR_BIT]});
   wire is_verify = (xfer == fcd_pkg::FCD_VERIFY);
   wire is_last = (sel_cnt[`FCD_CNT_MSB:0] == 14'h0000);
   wire mark_hit = (sel_cnt[6:0] == `FCD_MARK_MASK) && !is_last;
   wire ext_wr = mode_reg[`FCD_MS_EXT_WRITE];
   wire stop_end = mode_reg[`FCD_MS_STOP_END];
   // ==========================================
   // register port with byte toggle
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         always_ff @(posedge ref_clk_in) begin
            if (link.reg_wr && is_chan && reg_ch == 3'(g)) begin
               if (is_cnt) begin
                  if (toggle_reg) cnt_reg[g][15:8] <= link.reg_wdata;
                  else cnt_reg[g][7:0] <= link.reg_wdata;
               end else begin
                  if (toggle_reg) addr_reg[g][15:8] <= link.reg_wdata;
                  else addr_reg[g][7:0] <= link.reg_wdata;
               end
            end else if (state_reg == FCD_S4 && sel_reg == 2'(g)) begin
               addr_reg[g] <= addr_reg[g] + 16'h0001;
               cnt_reg[g][`FCD_CNT_MSB:0] <= cnt_reg[g][`FCD_CNT_MSB:0] - 14'h0001;
            end
         end
      end
   endgenerate
   wire [15:0] rd_word = is_cnt ? cnt_reg[reg_ch[1:0]] : addr_reg[reg_ch[1:0]];
   wire [7:0] rd_chan = toggle_reg ? rd_word[15:8] : rd_word[7:0];
   wire [7:0] status_val = {3'b000, reload_reg, done_reg};
   wire [7:0] rd_next = is_chan ? rd_chan : status_val;
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         toggle_reg <= 1'b0;
         mode_reg <= `FCD_MS_RESET;
         rdata_reg <= 8'h00;
      end else begin
         if ((link.reg_wr || link.reg_rd) && is_chan) toggle_reg <= ~toggle_reg;
         else if (link.reg_wr && !is_chan) toggle_reg <= 1'b0;
         if (link.reg_wr && link.reg_addr == `FCD_OFS_MODE_SET) mode_reg <= link.reg_wdata;
         if (link.reg_rd) rdata_reg <= rd_next;
      end
   end
   // status: done set wins over read clear
   wire done_evt = (state_reg == FCD_S4) && is_last;
   wire stat_rd = link.reg_rd && link.reg_addr == `FCD_OFS_STATUS;
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         done_reg <= '0;
         reload_reg <= 1'b0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (done_evt && sel_reg == 2'(i)) done_reg[i] <= 1'b1;
            else if (stat_rd) done_reg[i] <= 1'b0;
         end
         reload_reg <= mode_reg[`FCD_MS_AUTO_RELOAD] && !(stat_rd && !done_evt);
      end
   end
   // ==========================================
   // transfer sequencer
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state_reg <= FCD_IDLE;
         sel_reg <= 2'h0;
      end else begin
         case (state_reg)
            FCD_IDLE: if (any_req) state_reg <= FCD_GRANT_WAIT;
            FCD_GRANT_WAIT: if (!any_req) state_reg <= FCD_IDLE;
               else if (link.hold_grant) state_reg <= FCD_S0;
            FCD_S0: begin
               sel_reg <= pick;
               state_reg <= FCD_S1;
            end
            FCD_S1: state_reg <= FCD_S2;
            FCD_S2: state_reg <= FCD_S3;
            FCD_S3: state_reg <= (link.ready || is_verify) ? FCD_S4 : FCD_SW;
            FCD_SW: if (link.ready) state_reg <= FCD_S4;
            FCD_S4: state_reg <= FCD_IDLE;
            default: state_reg <= FCD_IDLE;
         endcase
      end
   end
   // ==========================================
   // outputs, all registered
   wire in_s2 = state_reg == FCD_S2;
   wire in_s3 = state_reg == FCD_S3 || state_reg == FCD_SW;
   wire going_s1 = state_reg == FCD_S0;
   wire going_s2 = state_reg == FCD_S1;
   wire going_s3 = in_s2 || (in_s3 && state_reg == FCD_SW && !link.ready);
   wire hold_s3 = state_reg == FCD_S3 && !(link.ready || is_verify);
   wire s3_next = going_s3 || hold_s3;
   wire rd_on = going_s2 || s3_next; // strobe from S2 until end of S3
   wire wr_on = s3_next || (ext_wr && going_s2);
   wire rd_mode = xfer == fcd_pkg::FCD_READ;
   wire wr_mode = xfer == fcd_pkg::FCD_WRITE;
   wire [CHANNELS-1:0] sel_onehot = {{(CHANNELS-1){1'b0}}, 1'b1} << sel_reg;
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         hrq_reg <= 1'b0;
         aen_reg <= 1'b0;
         oe_reg <= 1'b0;
         alow_reg <= 8'h00;
         dout_reg <= 8'h00;
         channel_grant_out_reg <= '0;
         memrd_reg <= 1'b0;
         memwr_reg <= 1'b0;
         iord_reg <= 1'b0;
         iowr_reg <= 1'b0;
         tc_reg <= 1'b0;
         mark_reg <= 1'b0;
      end else begin
         hrq_reg <= (state_reg != FCD_IDLE && state_reg != FCD_S4) || any_req;
         aen_reg <= going_s1 || (state_reg != FCD_IDLE && state_reg != FCD_GRANT_WAIT
            && state_reg != FCD_S0 && state_reg != FCD_S4);
         oe_reg <= going_s1;
         alow_reg <= going_s1 ? addr_reg[pick][7:0] : sel_addr[7:0];
         dout_reg <= addr_reg[pick][15:8];
         channel_grant_out_reg <= (going_s2 || s3_next) ? sel_onehot : '0;
         memrd_reg <= rd_mode && rd_on;
         iowr_reg <= rd_mode && wr_on;
         iord_reg <= wr_mode && rd_on;
         memwr_reg <= wr_mode && wr_on;
         tc_reg <= s3_next && is_last && (stop_end || 1'b1);
         mark_reg <= s3_next && mark_hit;
      end
   end
   assign link.hold_request = hrq_reg;
   assign link.address_enable = aen_reg;
   assign link.data_oe = oe_reg;
   assign link.addr_low = alow_reg;
   assign link.data_out = dout_reg;
   assign link.channel_grant = channel_grant_out_reg;
   assign link.mem_rd = memrd_reg;
   assign link.mem_wr = memwr_reg;
   assign link.io_rd = iord_reg;
   assign link.io_wr = iowr_reg;
   assign link.terminal_count = tc_reg;
   assign link.mark = mark_reg;
   assign link.reg_rdata = rdata_reg;
endmodule // fcd_device

// ===== hw/fcd_host.sv
`timescale 1ns/100ps
`include "fcd_defs.svh"
// ==========================================
// host end: avalon slave driving register port and hold grant
module fcd_host (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [2:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [3:0] dma_request_in,
   input wire logic ready_in,
   fcd_link_if.host link
);
   logic [3:0] addr_reg;
   logic [7:0] wdata_reg;
   logic wr_reg, rd_reg, grant_reg, auto_grant_reg, busy_reg;
   logic rd_dly_reg;
   logic [7:0] rdata_reg;
   logic [31:0] avs_rdata_reg;
   logic wait_reg;
   logic [3:0] req_reg;
   logic ready_reg;
   wire ctrl_wr = avs_write_in && avs_address_in == `FCD_HR_CTRL && !busy_reg;
   wire ctrl_go_rd = ctrl_wr && avs_writedata_in[8];
   wire [31:0] rd_mux = (avs_address_in == `FCD_HR_RDATA) ? {24'h000000, rdata_reg} :
      (avs_address_in == `FCD_HR_STATUS) ? {30'h0, link.hold_request, busy_reg} :
      (avs_address_in == `FCD_HR_HOLD) ? {31'h0, auto_grant_reg} : 32'h00000000;
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         addr_reg <= 4'h0;
         wdata_reg <= 8'h00;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         rd_dly_reg <= 1'b0;
         busy_reg <= 1'b0;
         rdata_reg <= 8'h00;
         avs_rdata_reg <= 32'h00000000;
         wait_reg <= 1'b1;
         auto_grant_reg <= 1'b0;
         grant_reg <= 1'b0;
         req_reg <= 4'h0;
         ready_reg <= 1'b0;
      end else begin
         wait_reg <= !(avs_read_in || avs_write_in) || !wait_reg;
         if ((avs_read_in || avs_write_in) && wait_reg) avs_rdata_reg <= rd_mux;
         wr_reg <= ctrl_wr && wait_reg && !ctrl_go_rd;
         rd_reg <= ctrl_go_rd && wait_reg;
         rd_dly_reg <= rd_reg;
         if (ctrl_wr && wait_reg) begin
            addr_reg <= avs_writedata_in[15:12];
            wdata_reg <= avs_writedata_in[7:0];
            busy_reg <= 1'b1;
         end else if (busy_reg && !rd_reg && !rd_dly_reg) begin
            // stay busy until the device's registered read byte is captured
            busy_reg <= 1'b0;
         end
         if (rd_dly_reg) rdata_reg <= link.reg_rdata;
         if (avs_write_in && avs_address_in == `FCD_HR_HOLD && wait_reg)
            auto_grant_reg <= avs_writedata_in[0];
         grant_reg <= auto_grant_reg && link.hold_request;
         req_reg <= dma_request_in;
         ready_reg <= ready_in;
      end
   end
   assign avs_waitrequest_out = wait_reg;
   assign avs_readdata_out = avs_rdata_reg;
   assign link.reg_addr = addr_reg;
   assign link.reg_wdata = wdata_reg;
   assign link.reg_wr = wr_reg;
   assign link.reg_rd = rd_reg;
   assign link.hold_grant = grant_reg;
   assign link.dma_request = req_reg;
   assign link.ready = ready_reg;
endmodule // fcd_host

// ===== inc/fcd_defs.svh
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH
// ==========================================
// register offsets (port index, one byte wide)
`define FCD_OFS_CH_ADDR0 4'h0
`define FCD_OFS_CH_CNT0 4'h1
`define FCD_OFS_MODE_SET 4'h8
`define FCD_OFS_STATUS 4'h8
// ==========================================
// count register fields
`define FCD_CNT_RD_BIT 15
`define FCD_CNT_WR_BIT 14
`define FCD_CNT_MSB 13
// ==========================================
// mode-set fields
`define FCD_MS_AUTO_RELOAD 7
`define FCD_MS_STOP_END 6
`define FCD_MS_EXT_WRITE 5
`define FCD_MS_ROT_PRIO 4
`define FCD_MS_RESET 8'h00
`define FCD_STATUS_RELOAD_BIT 4
`define FCD_MARK_MASK 7'h7F
// ==========================================
// host register map (avalon word index)
`define FCD_HR_CTRL 3'h0
`define FCD_HR_WDATA 3'h1
`define FCD_HR_RDATA 3'h2
`define FCD_HR_STATUS 3'h3
`define FCD_HR_HOLD 3'h4
`endif

// ===== inc/fcd_link_if.sv
`timescale 1ns/100ps
// ==========================================
// link between the dma device and its host/peripheral side
interface fcd_link_if;
   logic [3:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [3:0] dma_request;
   logic hold_request;
   logic hold_grant;
   logic [3:0] channel_grant;
   logic address_enable;
   logic [7:0] addr_low;
   logic [7:0] data_out;
   logic data_oe;
   logic mem_rd;
   logic mem_wr;
   logic io_rd;
   logic io_wr;
   logic terminal_count;
   logic mark;
   logic ready;
   modport device (input reg_addr, reg_wr, reg_rd, reg_wdata, dma_request, hold_grant,
      ready, output reg_rdata, hold_request, channel_grant, address_enable, addr_low,
      data_out, data_oe, mem_rd, mem_wr, io_rd, io_wr, terminal_count, mark);
   modport host (output reg_addr, reg_wr, reg_rd, reg_wdata, dma_request, hold_grant,
      ready, input reg_rdata, hold_request, channel_grant, address_enable, addr_low,
      data_out, data_oe, mem_rd, mem_wr, io_rd, io_wr, terminal_count, mark);
endinterface

// ===== inc/fcd_pkg.sv
package fcd_pkg;
   typedef enum logic [1:0] {
      FCD_VERIFY,
      FCD_WRITE,
      FCD_READ,
      FCD_ILLEGAL
   } fcd_xfer_e;
endpackage

// ===== verification/fcd_link_asserts.sv
`timescale 1ns/100ps
// ==========================================
// link protocol checks
module fcd_link_asserts (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [3:0] dma_request,
   input wire logic hold_request,
   input wire logic hold_grant,
   input wire logic [3:0] channel_grant,
   input wire logic address_enable,
   input wire logic data_oe,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic terminal_count,
   input wire logic mark,
   input wire logic ready
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);
   property p_hold_cause;
      $rose(hold_request) |-> $past(dma_request) != 4'h0;
   endproperty
   a_hold_cause: assert property (p_hold_cause)
      else $error("hold request raised with no channel request");
   property p_grant_start;
      $rose(hold_grant) |-> ##[1:3] data_oe;
   endproperty
   a_grant_start: assert property (p_grant_start)
      else $error("no address phase after hold grant");
   property p_addr_en;
      data_oe |-> address_enable && channel_grant == 4'h0;
   endproperty
   a_addr_en: assert property (p_addr_en)
      else $error("address phase without address enable");
   // address phase lasts one cycle, then the selected channel is acknowledged
   property p_addr_phase;
      $rose(data_oe) |=> !data_oe && $onehot(channel_grant);
   endproperty
   a_addr_phase: assert property (p_addr_phase)
      else $error("address phase not followed by channel grant");
   property p_rd_pair;
      mem_rd |-> !io_rd && !mem_wr;
   endproperty
   a_rd_pair: assert property (p_rd_pair)
      else $error("memory read paired with wrong strobe");
   property p_wr_pair;
      mem_wr |-> !io_wr && !mem_rd;
   endproperty
   a_wr_pair: assert property (p_wr_pair)
      else $error("memory write paired with wrong strobe");
   property p_tc_phase;
      terminal_count |-> (channel_grant != 4'h0) && address_enable;
   endproperty
   a_tc_phase: assert property (p_tc_phase)
      else $error("terminal count outside transfer phase");
   property p_mark_phase;
      mark |-> (channel_grant != 4'h0) && !data_oe;
   endproperty
   a_mark_phase: assert property (p_mark_phase)
      else $error("mark outside transfer phase");
   property p_wait;
      (channel_grant != 4'h0) && !ready && (mem_wr || io_wr) |=> channel_grant != 4'h0;
   endproperty
   a_wait: assert property (p_wait)
      else $error("transfer ended while ready low");
endmodule // fcd_link_asserts

// ===== verification/test_four_channel_dma_sequencer.sv
`timescale 1ns/100ps
`include "fcd_defs.svh"
module test_four_channel_dma_sequencer;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [2:0] av_addr = 3'h0;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wdata = 32'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic [3:0] dreq = 4'h0;
   logic rdy = 1'b1;
   logic [31:0] rd_word = 32'h0;
   logic [7:0] lo_q = 8'h00;
   logic [7:0] hi_q = 8'h00;
   logic [6:0] cur;
   logic [6:0] prv = 7'h00;
   int rises [7] = '{default: 0};
   int base [7];
   int error_cnt = 0;
   int check_count = 0;
   fcd_link_if link ();
   fcd_device fcd_device_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(link.device));
   fcd_host fcd_host_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
      .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
      .dma_request_in(dreq), .ready_in(rdy), .link(link.host));
   fcd_link_asserts fcd_link_asserts_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .dma_request(link.dma_request), .hold_request(link.hold_request),
      .hold_grant(link.hold_grant), .channel_grant(link.channel_grant),
      .address_enable(link.address_enable), .data_oe(link.data_oe), .mem_rd(link.mem_rd),
      .mem_wr(link.mem_wr), .io_rd(link.io_rd), .io_wr(link.io_wr),
      .terminal_count(link.terminal_count), .mark(link.mark), .ready(link.ready));
   always #25 ref_clk_in = ~ref_clk_in;
   // ==========================================
   // link monitor: counts rising strobes, latches the address phase
   assign cur = {link.mem_rd, link.mem_wr, link.io_rd, link.io_wr,
      link.terminal_count, link.mark, link.hold_request};
   always @(posedge ref_clk_in) begin
      for (int k = 0; k < 7; k++) begin
         if (cur[k] === 1'b1 && prv[k] !== 1'b1) rises[k] <= rises[k] + 1;
      end
      prv <= cur;
      if (link.data_oe === 1'b1) begin
         lo_q <= link.addr_low;
         hi_q <= link.data_out;
      end
   end
   // ==========================================
   // access tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk_in);
      av_addr <= a;
      av_wr <= w;
      av_rd <= !w;
      av_wdata <= d;
      @(posedge ref_clk_in);
      while (av_wait !== 1'b0) @(posedge ref_clk_in);
      rd_word = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
   endtask
   task automatic port(input logic [3:0] p, input logic w, input logic [7:0] d);
      av(`FCD_HR_CTRL, 1'b1, {16'h0, p, 3'h0, !w, d});
      do av(`FCD_HR_STATUS, 1'b0, 32'h0); while (rd_word[0] !== 1'b0);
      if (!w) av(`FCD_HR_RDATA, 1'b0, 32'h0);
   endtask
   task automatic rdchk(input logic [3:0] p, input logic [7:0] exp);
      port(p, 1'b0, 8'h00);
      chk({8'h00, rd_word[7:0]}, {8'h00, exp});
   endtask
   task automatic prog(input logic [15:0] cnt);
      port(`FCD_OFS_CH_ADDR0, 1'b1, 8'h34);
      port(`FCD_OFS_CH_ADDR0, 1'b1, 8'h12);
      port(`FCD_OFS_CH_CNT0, 1'b1, cnt[7:0]);
      port(`FCD_OFS_CH_CNT0, 1'b1, cnt[15:8]);
   endtask
   // exp holds expected rises as nibbles: mem_rd, mem_wr, io_rd, io_wr, tc, mark
   task automatic dma(input logic [15:0] cnt, input logic rl, input int stall,
         input logic [27:0] exp);
      prog(cnt);
      port(`FCD_OFS_MODE_SET, 1'b1, 8'h01);
      base = rises;
      rdy <= rl;
      dreq <= 4'h1;
      if (stall > 0) begin
         repeat (stall) @(posedge ref_clk_in);
         chk(16'(rises[6] - base[6]), 16'h0001);
         rdy <= 1'b1;
      end
      // the peripheral lets go at the last byte, so no extra cycle is started
      for (int i = 0; i < 3000 && link.terminal_count !== 1'b1; i++) @(posedge ref_clk_in);
      dreq <= 4'h0;
      repeat (10) @(posedge ref_clk_in);
      rdy <= 1'b1;
      port(`FCD_OFS_MODE_SET, 1'b1, 8'h00);
      for (int k = 1; k < 7; k++) chk(16'(rises[k] - base[k]), {12'h000, exp[4*k-4 +: 4]});
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (10) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      av(`FCD_HR_HOLD, 1'b1, 32'h1);
      rdchk(`FCD_OFS_STATUS, 8'h00);
      prog(16'h8001);
      rdchk(`FCD_OFS_CH_ADDR0, 8'h34);
      rdchk(`FCD_OFS_CH_ADDR0, 8'h12);
      rdchk(`FCD_OFS_CH_CNT0, 8'h01);
      rdchk(`FCD_OFS_CH_CNT0, 8'h80);
      port(`FCD_OFS_MODE_SET, 1'b1, 8'h72);
      base = rises;
      dreq <= 4'h1;
      repeat (20) @(posedge ref_clk_in);
      chk(16'(rises[0] - base[0]), 16'h0000);
      dreq <= 4'h0;
      port(`FCD_OFS_MODE_SET, 1'b1, 8'h00);
      dma(16'h8001, 1'b0, 40, 28'h2002_10);
      chk({hi_q, lo_q}, 16'h1235);
      rdchk(`FCD_OFS_STATUS, 8'h01);
      rdchk(`FCD_OFS_STATUS, 8'h00);
      rdchk(`FCD_OFS_CH_ADDR0, 8'h36);
      rdchk(`FCD_OFS_CH_ADDR0, 8'h12);
      dma(16'h4000, 1'b1, 0, 28'h0110_10);
      dma(16'h007F, 1'b0, 0, 28'h0000_11);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      error_cnt++;
      wrap_up();
   end
endmodule // test_four_channel_dma_sequencer
